// [hw/sacd_pkg.sv]
// Package with register map, field layouts and decode tables for the stage config bank
package sacd_pkg;

  // Register bank geometry
  localparam int SACD_STAGES = 8;
  localparam int SACD_WORD_W = 16;
  localparam int SACD_SEL_W = 2;
  localparam int SACD_STAGE_W = 3;
  localparam int SACD_ADDR_W = SACD_STAGE_W + SACD_SEL_W;

  // Per-stage word select, relative to the stage base
  localparam logic [SACD_SEL_W-1:0] SACD_SEL_ROUTE = 2'h1;
  localparam logic [SACD_SEL_W-1:0] SACD_SEL_OFFSET = 2'h2;
  localparam logic [SACD_SEL_W-1:0] SACD_SEL_SENSE = 2'h3;

  // Routing word fields
  localparam int SACD_RT_ROUTE_LO = 0;
  localparam int SACD_RT_MODE_LO = 12;
  localparam int SACD_RT_MOFF_BIT = 14;
  localparam int SACD_RT_POFF_BIT = 15;

  // Offset word fields
  localparam int SACD_OF_MMAG_LO = 0;
  localparam int SACD_OF_MSWAP_BIT = 7;
  localparam int SACD_OF_PMAG_LO = 8;
  localparam int SACD_OF_PSWAP_BIT = 15;
  localparam int SACD_MAG_W = 6;

  // Sensitivity word fields
  localparam int SACD_SN_MTHR_LO = 0;
  localparam int SACD_SN_MPK_LO = 4;
  localparam int SACD_SN_PTHR_LO = 8;
  localparam int SACD_SN_PPK_LO = 12;

  // Reset value of all words; the hardware defines none, cleared here so decode starts known
  localparam logic [SACD_WORD_W-1:0] SACD_WORD_RST = 16'h0000;

  // Offset step in femtofarads per code (0.32 pF)
  localparam int SACD_OFFSET_STEP_FF = 320;

  // Routing of sense input 7
  typedef enum logic [1:0] {
    SACD_IN7_OPEN = 2'h0,
    SACD_IN7_NEG = 2'h1,
    SACD_IN7_POS = 2'h2,
    SACD_IN7_BIAS = 2'h3
  } sacd_route_t;

  // Measurement mode
  typedef enum logic [1:0] {
    SACD_MODE_BAD = 2'h0,
    SACD_MODE_SE_POS = 2'h1,
    SACD_MODE_SE_NEG = 2'h2,
    SACD_MODE_DIFF = 2'h3
  } sacd_mode_t;

  // Highest defined peak code and the peak level step
  localparam logic [2:0] SACD_PEAK_MAX_CODE = 3'h5;
  localparam logic [6:0] SACD_PEAK_BASE_PCT = 7'h28;
  localparam logic [6:0] SACD_PEAK_STEP_PCT = 7'h0a;

  // Threshold percentages in hundredths of a percent, codes 0 to 15
  localparam logic [13:0] SACD_THR_TABLE [16] = '{
    14'h09c4, 14'h0b9d, 14'h0d70, 14'h0f44, 14'h111b, 14'h12f0, 14'h14c3, 14'h1697,
    14'h186b, 14'h1a42, 14'h1c16, 14'h1dea, 14'h1fc0, 14'h2194, 14'h2368, 14'h253c};

  // Decoded front-end setup of one stage
  typedef struct packed {
    sacd_route_t in7Route;
    sacd_mode_t measMode;
    logic modeValid;
    logic [SACD_MAG_W-1:0] negOffMag;
    logic [SACD_MAG_W-1:0] posOffMag;
    logic [SACD_MAG_W-1:0] offToNeg;
    logic [SACD_MAG_W-1:0] offToPos;
    logic [13:0] negThrCentiPct;
    logic [13:0] posThrCentiPct;
    logic [6:0] negPeakPct;
    logic [6:0] posPeakPct;
  } sacd_setup_t;

endpackage

// [hw/sacd_stage_decode.sv]
// Decoder turning one stage's three configuration words into front-end settings
`timescale 1ns/1ns
module sacd_stage_decode
  import sacd_pkg::*;
(
  input wire logic [SACD_WORD_W-1:0] routeWord,
  input wire logic [SACD_WORD_W-1:0] offsetWord,
  input wire logic [SACD_WORD_W-1:0] senseWord,
  output sacd_setup_t setup
);

  // Peak level: 40 % plus 10 % per code, undefined codes clamp to the top
  function automatic logic [6:0] peak_pct(input logic [2:0] code);
    logic [2:0] c;
    c = (code > SACD_PEAK_MAX_CODE) ? SACD_PEAK_MAX_CODE : code;
    return 7'(SACD_PEAK_BASE_PCT + 7'(c) * SACD_PEAK_STEP_PCT);
  endfunction

  // Effective magnitude: zero when the offset is switched off
  function automatic logic [SACD_MAG_W-1:0] gated(input logic off,
                                                 input logic [SACD_MAG_W-1:0] mag);
    return off ? '0 : mag;
  endfunction

  wire logic minusOff = routeWord[SACD_RT_MOFF_BIT];
  wire logic plusOff = routeWord[SACD_RT_POFF_BIT];
  wire logic minusSwap = offsetWord[SACD_OF_MSWAP_BIT];
  wire logic plusSwap = offsetWord[SACD_OF_PSWAP_BIT];
  wire logic [SACD_MAG_W-1:0] minusMag =
    gated(minusOff, offsetWord[SACD_OF_MMAG_LO +: SACD_MAG_W]);
  wire logic [SACD_MAG_W-1:0] plusMag =
    gated(plusOff, offsetWord[SACD_OF_PMAG_LO +: SACD_MAG_W]);

  assign setup.in7Route = sacd_route_t'(routeWord[SACD_RT_ROUTE_LO +: 2]);
  assign setup.measMode = sacd_mode_t'(routeWord[SACD_RT_MODE_LO +: 2]);
  assign setup.modeValid = (routeWord[SACD_RT_MODE_LO +: 2] != SACD_MODE_BAD);
  assign setup.negOffMag = minusMag;
  assign setup.posOffMag = plusMag;
  // Swap steers each offset to the opposite converter input
  assign setup.offToNeg =
    6'((minusSwap ? '0 : minusMag) + (plusSwap ? plusMag : '0));
  assign setup.offToPos =
    6'((minusSwap ? minusMag : '0) + (plusSwap ? '0 : plusMag));
  assign setup.negThrCentiPct = SACD_THR_TABLE[senseWord[SACD_SN_MTHR_LO +: 4]];
  assign setup.posThrCentiPct = SACD_THR_TABLE[senseWord[SACD_SN_PTHR_LO +: 4]];
  assign setup.negPeakPct = peak_pct(senseWord[SACD_SN_MPK_LO +: 3]);
  assign setup.posPeakPct = peak_pct(senseWord[SACD_SN_PPK_LO +: 3]);

endmodule

// [hw/sacd_stage_bank.sv]
// Eight-stage configuration word bank with front-end decode of the active stage
`timescale 1ns/1ns
module sacd_stage_bank
  import sacd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic [SACD_ADDR_W-1:0] regAddr,
  input wire logic [SACD_WORD_W-1:0] regWdata,
  output logic [SACD_WORD_W-1:0] regRdata,
  output logic regHit,
  input wire logic [SACD_STAGE_W-1:0] activeStage,
  output sacd_setup_t stageSetup,
  output logic modeError
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  ////////////////////////////////////////////////////////////////////////////

  // One routing, offset and sensitivity word per stage
  logic [SACD_WORD_W-1:0] routeMem [SACD_STAGES];
  logic [SACD_WORD_W-1:0] offsetMem [SACD_STAGES];
  logic [SACD_WORD_W-1:0] senseMem [SACD_STAGES];

  // Address split into stage and word select
  wire logic [SACD_STAGE_W-1:0] addrStage = regAddr[SACD_ADDR_W-1:SACD_SEL_W];
  wire logic [SACD_SEL_W-1:0] addrSel = regAddr[SACD_SEL_W-1:0];
  wire logic selRoute = (addrSel == SACD_SEL_ROUTE);
  wire logic selOffset = (addrSel == SACD_SEL_OFFSET);
  wire logic selSense = (addrSel == SACD_SEL_SENSE);
  // Word 0 of each stage (input 0-6 routing) is not held here
  assign regHit = selRoute | selOffset | selSense;

  // Stored words; unused bits kept as written since the host must write zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SACD_STAGES; i++) begin
        routeMem[i] <= SACD_WORD_RST;
        offsetMem[i] <= SACD_WORD_RST;
        senseMem[i] <= SACD_WORD_RST;
      end
    end else if (regWrite) begin
      if (selRoute) routeMem[addrStage] <= regWdata;
      if (selOffset) offsetMem[addrStage] <= regWdata;
      if (selSense) senseMem[addrStage] <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  ////////////////////////////////////////////////////////////////////////////

  // Read data mux; unmapped word reads as zero
  wire logic [SACD_WORD_W-1:0] next_regRdata =
    selRoute ? routeMem[addrStage] :
    selOffset ? offsetMem[addrStage] :
    selSense ? senseMem[addrStage] : '0;

  // Registered read data, one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) regRdata <= '0;
    else regRdata <= next_regRdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the active stage
  ////////////////////////////////////////////////////////////////////////////

  // Combinational decode of the stage the sequencer is converting
  sacd_setup_t next_stageSetup;
  sacd_stage_decode uDecode (
    .routeWord(routeMem[activeStage]),
    .offsetWord(offsetMem[activeStage]),
    .senseWord(senseMem[activeStage]),
    .setup(next_stageSetup)
  );

  // Setup registered so the front end sees clean levels
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stageSetup <= '0;
      modeError <= 1'b0;
    end else begin
      stageSetup <= next_stageSetup;
      modeError <= ~next_stageSetup.modeValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////

  // Words of the stage under decode; the registered setup follows them one edge later
  wire logic [SACD_WORD_W-1:0] curRoute = routeMem[activeStage];
  wire logic [SACD_WORD_W-1:0] curOffset = offsetMem[activeStage];
  wire logic [SACD_WORD_W-1:0] curSense = senseMem[activeStage];
  // Field views of those words, so the checks read like the field map
  wire logic [1:0] curIn7 = curRoute[SACD_RT_ROUTE_LO +: 2];
  wire logic [1:0] curMode = curRoute[SACD_RT_MODE_LO +: 2];
  wire logic curMinusOff = curRoute[SACD_RT_MOFF_BIT];
  wire logic curPlusOff = curRoute[SACD_RT_POFF_BIT];
  wire logic curMinusSwap = curOffset[SACD_OF_MSWAP_BIT];
  wire logic curPlusSwap = curOffset[SACD_OF_PSWAP_BIT];
  wire logic [SACD_MAG_W-1:0] curMinusMag = curOffset[SACD_OF_MMAG_LO +: SACD_MAG_W];
  wire logic [SACD_MAG_W-1:0] curPlusMag = curOffset[SACD_OF_PMAG_LO +: SACD_MAG_W];
  wire logic [3:0] curMinusThr = curSense[SACD_SN_MTHR_LO +: 4];
  wire logic [3:0] curPlusThr = curSense[SACD_SN_PTHR_LO +: 4];
  wire logic [2:0] curMinusPk = curSense[SACD_SN_MPK_LO +: 3];
  wire logic [2:0] curPlusPk = curSense[SACD_SN_PPK_LO +: 3];

  // A write strobe on one word select
  sequence write_seq(logic [SACD_SEL_W-1:0] s);
    regWrite && addrSel == s;
  endsequence

  // Write, then an idle cycle on the same address; read data then shows the new word
  sequence write_idle_seq(logic [SACD_SEL_W-1:0] s);
    write_seq(s) ##1 (!regWrite && $stable(regAddr)) ##1 1'b1;
  endsequence

  // Write to a stage other than the decoded one, which then stays selected
  sequence foreign_write_seq;
    (regWrite && regHit && addrStage != activeStage) ##1 $stable(activeStage);
  endsequence

  // Antecedents carry rst_n: the first edge after release still shows reset values
  route_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> stageSetup.in7Route == $past(curIn7))
    else $error("input-7 routing mismatch");
  mode_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> (stageSetup.measMode == $past(curMode)
    && modeError == ($past(curMode) == 2'h0)))
    else $error("measurement mode mismatch");

  // Offset disables and magnitudes
  minus_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusOff) |=> stageSetup.negOffMag == 6'h00)
    else $error("minus offset not disabled");
  plus_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusOff) |=> stageSetup.posOffMag == 6'h00)
    else $error("plus offset not disabled");
  minus_mag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && !curMinusOff) |=> stageSetup.negOffMag == $past(curMinusMag))
    else $error("minus offset magnitude wrong");
  plus_mag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && !curPlusOff) |=> stageSetup.posOffMag == $past(curPlusMag))
    else $error("plus offset magnitude wrong");

  // Swap steering, all four swap combinations
  minus_swap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusSwap && !curPlusSwap) |=> stageSetup.offToNeg == 6'h00)
    else $error("minus swap not applied");
  plus_swap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusSwap && !curMinusSwap) |=> stageSetup.offToPos == 6'h00)
    else $error("plus swap not applied");
  steer_plain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && !curMinusSwap && !curPlusSwap) |=>
    (stageSetup.offToNeg == stageSetup.negOffMag
    && stageSetup.offToPos == stageSetup.posOffMag))
    else $error("unswapped offsets misrouted");
  steer_cross_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusSwap && curPlusSwap) |=>
    (stageSetup.offToNeg == stageSetup.posOffMag
    && stageSetup.offToPos == stageSetup.negOffMag))
    else $error("double swap misrouted");

  // Threshold table end points and a middle code
  minus_thr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusThr == 4'hf) |=> stageSetup.negThrCentiPct == 14'h253c)
    else $error("minus threshold top wrong");
  minus_thr_mid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusThr == 4'h7) |=> stageSetup.negThrCentiPct == 14'h1697)
    else $error("minus threshold middle wrong");
  plus_thr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusThr == 4'h0) |=> stageSetup.posThrCentiPct == 14'h09c4)
    else $error("plus threshold base wrong");
  plus_thr_top_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusThr == 4'hf) |=> stageSetup.posThrCentiPct == 14'h253c)
    else $error("plus threshold top wrong");

  // Peak levels, base, a middle step and the clamped top
  minus_peak_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusPk == 3'h0) |=> stageSetup.negPeakPct == 7'h28)
    else $error("minus peak base wrong");
  minus_peak_mid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curMinusPk == 3'h3) |=> stageSetup.negPeakPct == 7'h46)
    else $error("minus peak middle wrong");
  plus_peak_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusPk >= 3'h5) |=> stageSetup.posPeakPct == 7'h5a)
    else $error("plus peak top wrong");
  plus_peak_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && curPlusPk == 3'h0) |=> stageSetup.posPeakPct == 7'h28)
    else $error("plus peak base wrong");

  // Storage and readback of each word select, and stage independence
  store_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_idle_seq(SACD_SEL_OFFSET) |-> regRdata == $past(regWdata, 2))
    else $error("stage word not stored");
  route_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_idle_seq(SACD_SEL_ROUTE) |-> regRdata == $past(regWdata, 2))
    else $error("routing word not stored");
  sense_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_idle_seq(SACD_SEL_SENSE) |-> regRdata == $past(regWdata, 2))
    else $error("sensitivity word not stored");
  sel0_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_seq(2'h0) |=> (routeMem[$past(addrStage)] == $past(routeMem[addrStage])
    && offsetMem[$past(addrStage)] == $past(offsetMem[addrStage])
    && senseMem[$past(addrStage)] == $past(senseMem[addrStage])))
    else $error("select zero write changed a word");
  stage_iso_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    foreign_write_seq |-> (curRoute == $past(curRoute)
    && curOffset == $past(curOffset) && curSense == $past(curSense)))
    else $error("write leaked into another stage");

  // Registered outputs come out of reset cleared
  reset_clear_a: assert property (@(posedge sys_clk)
    !rst_n |=> (regRdata == '0 && stageSetup == '0 && !modeError))
    else $error("outputs not cleared by reset");

endmodule

// [verif/sacd_stage_bank_bench.sv]
// Self-checking bench for the eight-stage configuration bank and its decode
`timescale 1ns/1ns
module sacd_stage_bank_bench
  import sacd_pkg::*;
;
////////////////////////////////////////////////////////////////////////////////
// Stimulus signals and bookkeeping
logic sys_clk;
logic rst_n;
logic regWrite;
logic [SACD_ADDR_W-1:0] regAddr;
logic [SACD_WORD_W-1:0] regWdata;
logic [SACD_WORD_W-1:0] regRdata;
logic regHit;
logic [SACD_STAGE_W-1:0] activeStage;
sacd_setup_t stageSetup;
logic modeError;
int error_cnt = 0;
int n_checks = 0;
int cycles = 0;
// Words as written, kept to compare read-back
logic [15:0] expWord [8][4];
// Threshold percentages in hundredths, kept apart from the design's table
int thrTab [16] = '{2500, 2973, 3440, 3908, 4379, 4848, 5315, 5783,
  6251, 6722, 7190, 7658, 8128, 8596, 9064, 9532};

sacd_stage_bank i_dut (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .regWrite(regWrite),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regRdata(regRdata),
  .regHit(regHit),
  .activeStage(activeStage),
  .stageSetup(stageSetup),
  .modeError(modeError)
);

////////////////////////////////////////////////////////////////////////////////
// Clock, and a cycle ceiling well above the few hundred cycles the run needs
initial begin
  sys_clk = 1'b0;
  forever #5 sys_clk = ~sys_clk;
end

always @(posedge sys_clk) begin
  cycles++;
  if (cycles == 5000) begin
    error_cnt++;
    final_report();
  end
end

////////////////////////////////////////////////////////////////////////////////
// Shared helpers
task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
  n_checks++;
  if (got !== exp) begin
    error_cnt++;
    $display("mismatch %s expected %h seen %h", nm, exp, got);
  end
endtask

// One write: strobe held for exactly one taken edge
task automatic wr(logic [4:0] a, logic [15:0] d);
  @(posedge sys_clk);
  regWrite <= 1'b1;
  regAddr <= a;
  regWdata <= d;
  @(posedge sys_clk);
  regWrite <= 1'b0;
endtask

// Read data lands one edge after the address is shown
task automatic rd(logic [4:0] a, logic [15:0] exp);
  @(posedge sys_clk);
  regAddr <= a;
  @(posedge sys_clk);
  #1;
  chk("regRdata", {16'h0, exp}, {16'h0, regRdata});
  chk("regHit", {31'h0, a[1:0] != 2'h0}, {31'h0, regHit});
endtask

// Expected decode worked out from the field meanings
task automatic chkSetup(logic [15:0] rt, logic [15:0] of, logic [15:0] sn);
  logic [5:0] nMag;
  logic [5:0] pMag;
  nMag = rt[14] ? 6'h0 : of[5:0];
  pMag = rt[15] ? 6'h0 : of[13:8];
  chk("in7Route", rt[1:0], stageSetup.in7Route);
  chk("measMode", rt[13:12], stageSetup.measMode);
  chk("modeValid", rt[13:12] != 2'h0, stageSetup.modeValid);
  chk("modeError", rt[13:12] == 2'h0, modeError);
  chk("negOffMag", nMag, stageSetup.negOffMag);
  chk("posOffMag", pMag, stageSetup.posOffMag);
  chk("offToNeg", 6'((of[7] ? 6'h0 : nMag) + (of[15] ? pMag : 6'h0)),
    stageSetup.offToNeg);
  chk("offToPos", 6'((of[7] ? nMag : 6'h0) + (of[15] ? 6'h0 : pMag)),
    stageSetup.offToPos);
  chk("negThr", thrTab[sn[3:0]], stageSetup.negThrCentiPct);
  chk("posThr", thrTab[sn[11:8]], stageSetup.posThrCentiPct);
  chk("negPeak", 40 + 10 * sn[6:4], stageSetup.negPeakPct);
  chk("posPeak", 40 + 10 * sn[14:12], stageSetup.posPeakPct);
endtask

// Per-stage word pattern; unused bits zero and mode never 00
function automatic logic [15:0] genWord(int s, int w);
  logic [2:0] v;
  v = 3'(s);
  case (w)
    1: return {v[0], v[1], 2'(s % 3 + 1), 10'h0, v[1:0]};
    2: return {v[0], 1'b0, 6'(s * 5 + 3), v[1], 1'b0, 6'(s * 7 + 1)};
    default: return {1'b0, 3'(s % 6), 4'(s + 8), 1'b0, 3'(5 - s % 6), 4'(15 - s)};
  endcase
endfunction

////////////////////////////////////////////////////////////////////////////////
// Scenarios
task automatic t_reset;
  rd({3'h2, SACD_SEL_OFFSET}, 16'h0000);
  chk("modeError", 32'h1, {31'h0, modeError});
  chk("measMode", 32'h0, {30'h0, stageSetup.measMode});
endtask

// Every stage keeps its own three words; select 0 is ignored
task automatic t_bank;
  for (int s = 0; s < 8; s++) begin
    for (int w = 1; w < 4; w++) begin
      expWord[s][w] = genWord(s, w);
      wr({3'(s), 2'(w)}, expWord[s][w]);
    end
  end
  wr({3'h3, 2'h0}, 16'hffff);
  for (int s = 0; s < 8; s++) begin
    for (int w = 0; w < 4; w++) begin
      rd({3'(s), 2'(w)}, (w == 0) ? 16'h0000 : expWord[s][w]);
    end
    @(posedge sys_clk);
    activeStage <= 3'(s);
    @(posedge sys_clk);
    #1;
    chkSetup(expWord[s][1], expWord[s][2], expWord[s][3]);
  end
endtask

// Sweep routes, legal modes, disables, swaps and all threshold codes
task automatic t_codes;
  logic [3:0] c;
  logic [15:0] rt;
  logic [15:0] of;
  logic [15:0] sn;
  @(posedge sys_clk);
  activeStage <= 3'h0;
  for (int i = 0; i < 16; i++) begin
    c = 4'(i);
    rt = {c[1:0], 2'(c[3:2] % 3 + 1), 10'h0, c[1:0] ^ c[3:2]};
    of = {c[0], 1'b0, 6'(63 - 3 * i), c[1], 1'b0, 6'(4 * i + 1)};
    sn = {1'b0, 3'(i % 6), c, 1'b0, 3'((i + 3) % 6), 4'(15 - i)};
    wr({3'h0, SACD_SEL_ROUTE}, rt);
    wr({3'h0, SACD_SEL_OFFSET}, of);
    wr({3'h0, SACD_SEL_SENSE}, sn);
    @(posedge sys_clk);
    #1;
    chkSetup(rt, of, sn);
  end
endtask

////////////////////////////////////////////////////////////////////////////////
// Verdict and main sequence
task final_report;
  $display("checks %0d errors %0d", n_checks, error_cnt);
  if (error_cnt == 0 && n_checks > 0) begin
    $display("== PASSED ==");
  end else begin
    $display("== FAILED ==");
  end
  $finish;
endtask

initial begin
  rst_n = 1'b0;
  regWrite = 1'b0;
  regAddr = '0;
  regWdata = '0;
  activeStage = '0;
  repeat (5) @(posedge sys_clk);
  rst_n <= 1'b1;
  t_reset();
  t_bank();
  t_codes();
  final_report();
end

endmodule
